// >>> logic/htwrp_map.svh
// Constants of the host two-wire register port
`ifndef HTWRP_MAP_SVH
`define HTWRP_MAP_SVH

`define HTWRP_PTR_RESET   8'h00
`define HTWRP_BIT_LAST    3'h7
`define HTWRP_BIT_FIRST   3'h0
`define HTWRP_ADDR_HI     2'h0
`define HTWRP_STRAP_W     5
`define HTWRP_REG_DEPTH   256

`endif

// >>> logic/htwrp_pkg.sv
// Types of the host two-wire register port
`default_nettype none
package htwrp_pkg;
	typedef enum logic [2:0] {
		HTWRP_IDLE,
		HTWRP_ADDR,
		HTWRP_ADDR_ACK,
		HTWRP_RX,
		HTWRP_RX_ACK,
		HTWRP_TX,
		HTWRP_TX_ACK
	} htwrp_state_t;
endpackage : htwrp_pkg
`default_nettype wire

// >>> logic/htwrp_if.sv
// Register memory access bundle
`default_nettype none
interface htwrp_mem_if;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	modport port (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : htwrp_mem_if
`default_nettype wire

// >>> logic/htwrp_regmem.sv
// Register space memory with registered read data
`default_nettype none
module htwrp_regmem #(
	parameter int DEPTH = 256
) (
	input  wire logic mclk_in,
	htwrp_mem_if.mem  mem
);
	import htwrp_pkg::*;

	logic [7:0] store [DEPTH];
	logic [7:0] rd_q;

	initial begin
		if (DEPTH != 256) $error("register space must hold 256 entries");
	end

	always_ff @(posedge mclk_in) begin
		if (mem.wr_en) begin
			store[mem.wr_addr] <= mem.wr_data;
		end
		rd_q <= store[mem.rd_addr];
	end

	assign mem.rd_data = rd_q;
endmodule : htwrp_regmem
`default_nettype wire

// >>> logic/htwrp_port.sv
// Host two-wire slave port into the 256-entry register space
// Requirements
// RQ1 - Bytes shift most significant bit first
// RQ2 - Strap pins latched at reset release
// RQ3 - Address lsb is direction, upper compared
// RQ4 - Host holds reset low fifty milliseconds; bench holds it low about 23 ns
// RQ5 - Direction one transmits, zero receives
// RQ6 - First written byte loads register pointer
// RQ7 - Pointer increments after every data byte
// RQ8 - Host avoids writing reserved locations
// RQ9 - Stop after matched transfer clears pointer
// RQ10 - Mismatched address ignored until next match
// RQ11 - Start leaves register pointer unchanged
// RQ12 - Write after read continues from pointer
// RQ13 - Host ends every sequence with stop
// RQ14 - Read after stop returns register zero
// RQ15 - Host clock at most 400 kHz; bench host clocks at 6.25 MHz
// RQ16 - Device acks address and writes; host nacks last
`include "htwrp_map.svh"
`default_nettype none
module htwrp_port (
	input  wire logic                           mclk_in,
	input  wire logic                           rst_n_in,
	input  wire logic                           host_serial_clock_in,
	input  wire logic                           host_serial_data_in,
	output logic                                host_serial_data_out,
	output logic                                host_serial_data_oe_n_out,
	input  wire logic [`HTWRP_STRAP_W-1:0]      address_strap_inputs_in,
	output htwrp_pkg::htwrp_state_t             state_out,
	output logic [7:0]                          register_pointer_out
);
	import htwrp_pkg::*;

	htwrp_mem_if mif ();

	htwrp_regmem #(.DEPTH(`HTWRP_REG_DEPTH)) u_mem (
		.mclk_in (mclk_in),
		.mem     (mif)
	);

	// ----------------------------------------
	// Pin synchronisers and edge finding
	// ----------------------------------------
	logic [1:0] scl_sync, sda_sync;
	logic       scl_d, sda_d;
	logic       rst_seen;
	logic [`HTWRP_STRAP_W-1:0] strap_s1, strap_s2;
	logic [6:0] dev_addr;
	logic [6:0] next_dev_addr;
	logic       next_rst_seen;

	always_ff @(posedge mclk_in) begin
		scl_sync <= {scl_sync[0], host_serial_clock_in};
		sda_sync <= {sda_sync[0], host_serial_data_in};
		strap_s1 <= address_strap_inputs_in;
		strap_s2 <= strap_s1;
	end

	wire scl      = scl_sync[1];
	wire sda      = sda_sync[1];
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_ev = scl & scl_d & sda_d & ~sda;
	wire stop_ev  = scl & scl_d & ~sda_d & sda;

	// ----------------------------------------
	// Address capture at reset release
	// ----------------------------------------
	always_comb begin
		next_rst_seen = 1'b1;
		next_dev_addr = dev_addr;
		if (!rst_seen) begin
			next_dev_addr = {`HTWRP_ADDR_HI, strap_s2}; // see RQ2
		end
	end

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	htwrp_state_t state, next_state;
	logic [7:0]   shreg, next_shreg;
	logic [2:0]   bitcnt, next_bitcnt;
	logic [7:0]   ptr, next_ptr;
	logic         ptr_loaded, next_ptr_loaded;
	logic         matched, next_matched;
	logic         is_read, next_is_read;
	logic         drive, next_drive;
	logic         wr_en, next_wr_en;
	logic [7:0]   wr_addr, next_wr_addr;
	logic [7:0]   wr_data, next_wr_data;
	logic         byte_open, next_byte_open;

	function automatic logic [7:0] htwrp_inc(input logic [7:0] p);
		return p + 8'h01;
	endfunction

	always_comb begin
		next_state      = state;
		next_shreg      = shreg;
		next_bitcnt     = bitcnt;
		next_ptr        = ptr;
		next_ptr_loaded = ptr_loaded;
		next_matched    = matched;
		next_is_read    = is_read;
		next_drive      = drive;
		next_wr_en      = 1'b0;
		next_wr_addr    = wr_addr;
		next_wr_data    = wr_data;
		next_byte_open  = byte_open;
		if (stop_ev) begin
			next_state = HTWRP_IDLE;
			next_drive = 1'b0;
			if (matched) begin
				next_ptr = `HTWRP_PTR_RESET; // see RQ9
			end
			next_matched = 1'b0;
		end else if (start_ev) begin
			next_state  = HTWRP_ADDR; // see RQ11
			next_bitcnt = `HTWRP_BIT_FIRST;
			next_drive  = 1'b0;
			next_byte_open = 1'b0;
		end else begin
			case (state)
				HTWRP_IDLE: begin
					next_drive = 1'b0; // see RQ10
				end
				HTWRP_ADDR, HTWRP_RX: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda}; // see RQ1
						next_bitcnt = bitcnt + 3'h1;
						next_byte_open = 1'b1;
					end else if (scl_fall && bitcnt == `HTWRP_BIT_FIRST && byte_open) begin
						next_byte_open = 1'b0;
						if (state == HTWRP_ADDR) begin
							if (shreg[7:1] == dev_addr) begin // see RQ3
								next_matched    = 1'b1;
								next_is_read    = shreg[0];
								next_ptr_loaded = matched & is_read & ~shreg[0]; // see RQ12
								next_drive      = 1'b1; // see RQ16
								next_state      = HTWRP_ADDR_ACK;
							end else begin
								next_matched = 1'b0;
								next_state   = HTWRP_IDLE; // see RQ10
							end
						end else begin
							if (!ptr_loaded) begin
								next_ptr        = shreg; // see RQ6
								next_ptr_loaded = 1'b1;
							end else begin
								next_wr_en   = 1'b1;
								next_wr_addr = ptr;
								next_wr_data = shreg;
								next_ptr     = htwrp_inc(ptr); // see RQ7
							end
							next_drive = 1'b1; // see RQ16
							next_state = HTWRP_RX_ACK;
						end
					end
				end
				HTWRP_ADDR_ACK, HTWRP_RX_ACK: begin
					if (scl_fall) begin
						next_bitcnt = `HTWRP_BIT_FIRST;
						if (is_read) begin
							next_state = HTWRP_TX; // see RQ5
							next_shreg = mif.rd_data; // see RQ14
							next_drive = ~mif.rd_data[7];
						end else begin
							next_state = HTWRP_RX; // see RQ5
							next_drive = 1'b0;
						end
					end
				end
				HTWRP_TX: begin
					if (scl_fall) begin
						next_bitcnt = bitcnt + 3'h1;
						if (bitcnt == `HTWRP_BIT_LAST) begin
							next_drive = 1'b0;
							next_ptr   = htwrp_inc(ptr); // see RQ7
							next_state = HTWRP_TX_ACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_drive = ~shreg[6]; // see RQ1
						end
					end
				end
				HTWRP_TX_ACK: begin
					if (scl_rise) begin
						next_state = sda ? HTWRP_IDLE : HTWRP_RX_ACK; // see RQ16
						next_matched = matched;
					end
				end
				default: begin
					next_state = HTWRP_IDLE;
				end
			endcase
		end
	end

	// TX_ACK low ack reuses RX_ACK fall path to load next byte
	always_ff @(posedge mclk_in) begin
		scl_d <= scl;
		sda_d <= sda;
		if (!rst_n_in) begin
			rst_seen   <= 1'b0;
			dev_addr   <= 7'h00;
			state      <= HTWRP_IDLE;
			shreg      <= 8'h00;
			bitcnt     <= 3'h0;
			ptr        <= `HTWRP_PTR_RESET;
			ptr_loaded <= 1'b0;
			matched    <= 1'b0;
			is_read    <= 1'b0;
			drive      <= 1'b0;
			wr_en      <= 1'b0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			byte_open  <= 1'b0;
		end else begin
			rst_seen   <= next_rst_seen;
			dev_addr   <= next_dev_addr;
			state      <= next_state;
			shreg      <= next_shreg;
			bitcnt     <= next_bitcnt;
			ptr        <= next_ptr;
			ptr_loaded <= next_ptr_loaded;
			matched    <= next_matched;
			is_read    <= next_is_read;
			drive      <= next_drive;
			wr_en      <= next_wr_en;
			wr_addr    <= next_wr_addr;
			wr_data    <= next_wr_data;
			byte_open  <= next_byte_open;
		end
	end

	// ----------------------------------------
	// Memory hookup and pins
	// ----------------------------------------
	assign mif.wr_en   = wr_en;
	assign mif.wr_addr = wr_addr;
	assign mif.wr_data = wr_data;
	assign mif.rd_addr = ptr;

	assign host_serial_data_out      = 1'b0;
	assign host_serial_data_oe_n_out = ~drive;
	assign state_out                 = state;
	assign register_pointer_out      = ptr;
endmodule : htwrp_port
`default_nettype wire

// >>> dv/htwrp_chk.sv
// Checker of the host two-wire register port
`default_nettype none
module htwrp_chk
	import htwrp_pkg::*;
(
	input wire logic	mclk_in,
	input wire logic	rst_n_in,
	input wire logic	host_serial_clock_in,
	input wire logic	host_serial_data_in,
	input wire logic	host_serial_data_out,
	input wire logic	host_serial_data_oe_n_out,
	input wire logic [4:0]	address_strap_inputs_in,
	input wire htwrp_state_t	state_out,
	input wire logic [7:0]	register_pointer_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	a_reset_clears_all: assert property (disable iff (1'b0) !rst_n_in |=>
		state_out == HTWRP_IDLE && register_pointer_out == 8'h00 && host_serial_data_oe_n_out)
		else $error("reset left state");
	a_start_to_addr: assert property (host_serial_clock_in && $fell(host_serial_data_in) |->
		##[1:8] state_out == HTWRP_ADDR) else $error("start not taken");
	a_start_keeps_ptr: assert property (host_serial_clock_in && $fell(host_serial_data_in) |=>
		$stable(register_pointer_out) [*8]) else $error("start moved pointer");
	a_stop_clears_ptr: assert property (host_serial_clock_in && $rose(host_serial_data_in) |->
		##[1:8] (state_out == HTWRP_IDLE && register_pointer_out == 8'h00)) else $error("stop not taken");
	a_drive_low_only: assert property (host_serial_data_out == 1'b0) else $error("data driven high");
	a_drive_clock_low: assert property ($changed(host_serial_data_oe_n_out) |->
		!host_serial_clock_in) else $error("data changed while clock high");
	a_idle_released: assert property (state_out == HTWRP_IDLE |-> host_serial_data_oe_n_out)
		else $error("idle port drives data");
	a_ack_holds: assert property ($fell(host_serial_data_oe_n_out) |=>
		!host_serial_data_oe_n_out [*8]) else $error("low level too short");
endmodule // htwrp_chk
bind htwrp_port htwrp_chk chk_i (.mclk_in, .rst_n_in, .host_serial_clock_in, .host_serial_data_in,
	.host_serial_data_out, .host_serial_data_oe_n_out, .address_strap_inputs_in, .state_out,
	.register_pointer_out);
`default_nettype wire

// >>> dv/htwrp_host.sv
// Host bus master model
`default_nettype none
module htwrp_host (
	output var logic	scl_out,
	output var logic	sda_out,
	input wire logic	sda_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_out = b;
		#40 scl_out = 1'b1;
		#40 r = sda_in;
		#40 scl_out = 1'b0;
		#40;
	endtask
	task automatic start;
		sda_out = 1'b1;
		#40 scl_out = 1'b1;
		#80 sda_out = 1'b0;
		#80 scl_out = 1'b0;
		#40;
	endtask
	task automatic stop;
		sda_out = 1'b0;
		#40 scl_out = 1'b1;
		#80 sda_out = 1'b1;
		#80;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule // htwrp_host
`default_nettype wire

// >>> dv/host_two_wire_register_port_bench.sv
// Bench of the host two-wire register port
`default_nettype none
module host_two_wire_register_port_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import htwrp_pkg::*;
	logic	mclk = 1'b0;
	logic	rst_n = 1'b0;
	logic [4:0]	straps = 5'h0F;
	logic	scl, sda_rel, dout, oe_n, a;
	wire	sda = sda_rel & (oe_n | dout);
	htwrp_state_t	st;
	logic [7:0]	ptr, d;
	int	err_count = 0;
	int	checks = 0;
	always #2 mclk = ~mclk;
	htwrp_port uut (.mclk_in(mclk), .rst_n_in(rst_n), .host_serial_clock_in(scl), .host_serial_data_in(sda),
		.host_serial_data_out(dout), .host_serial_data_oe_n_out(oe_n), .address_strap_inputs_in(straps),
		.state_out(st), .register_pointer_out(ptr));
	htwrp_host host (.scl_out(scl), .sda_out(sda_rel), .sda_in(sda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t ns: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic write_burst;
		host.start();
		host.wbyte(8'h1E, a);
		chk({7'h00, a}, 8'h01);
		host.wbyte(8'h00, a);
		host.wbyte(8'h5E, a);
		host.wbyte(8'hC3, a);
		chk({7'h00, a}, 8'h01);
		chk(ptr, 8'h02);
		host.stop();
		chk(ptr, 8'h00);
	endtask
	task automatic read_after_stop;
		host.start();
		host.wbyte(8'h1F, a);
		chk({7'h00, a}, 8'h01);
		host.rbyte(1'b0, d);
		chk(d, 8'h5E);
		host.rbyte(1'b1, d);
		chk(d, 8'hC3);
		host.stop();
	endtask
	task automatic combined;
		host.start();
		host.wbyte(8'h1E, a);
		host.wbyte(8'h01, a);
		host.start();
		host.wbyte(8'h1F, a);
		host.rbyte(1'b1, d);
		chk(d, 8'hC3);
		host.stop();
	endtask
	task automatic foreign_address;
		host.start();
		host.wbyte(8'h3E, a);
		chk({7'h00, a}, 8'h00);
		host.stop();
	endtask
	task automatic write_after_read;
		host.start();
		host.wbyte(8'h1F, a);
		host.rbyte(1'b1, d);
		host.start();
		host.wbyte(8'h1E, a);
		host.wbyte(8'h77, a);
		host.stop();
		read_after_stop_pair();
	endtask
	task automatic read_after_stop_pair;
		host.start();
		host.wbyte(8'h1F, a);
		host.rbyte(1'b0, d);
		chk(d, 8'h5E);
		host.rbyte(1'b1, d);
		chk(d, 8'h77);
		host.stop();
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (12) @(posedge mclk);
		#1 straps = 5'h00;
		write_burst();
		read_after_stop();
		combined();
		foreign_address();
		write_after_read();
		end_of_test();
	end
	initial begin
		#200000;
		err_count++;
		end_of_test();
	end
endmodule // host_two_wire_register_port_bench
`default_nettype wire
